// *** design/status_pkg.sv ***
// constants, types and helpers for the status words and error history block
package status_pkg;

   // ****************************************************************
   // data word space layout (word addresses)
   // ****************************************************************
   localparam logic [10:0] DATA_WORDS       = 11'd2000;
   localparam logic [10:0] PROG_WRITE_LIMIT = 11'd1000;
   localparam logic [10:0] LOG_PTR_ADDR     = 11'd969;
   localparam logic [10:0] LOG_FIRST_ADDR   = 11'd970;
   localparam logic [10:0] LOG_LAST_ADDR    = 11'd999;
   localparam logic [10:0] UNIT_AREA_BASE   = 11'd1000;
   localparam logic [10:0] UNIT_BLOCK_WORDS = 11'd100;
   localparam int          UNIT_BLOCKS      = 10;

   // ****************************************************************
   // error log shape
   // ****************************************************************
   localparam int          LOG_RECORDS      = 10;
   localparam int          LOG_REC_WORDS    = 3;
   localparam int          LOG_WORDS        = 30;
   localparam logic [15:0] LOG_PTR_EMPTY    = 16'h0000;
   localparam logic [15:0] LOG_PTR_FULL     = 16'h000A;
   localparam logic [4:0]  LOG_LAST_REC_IDX = 5'd27;
   localparam logic [7:0]  SEV_NON_FATAL    = 8'h00;
   localparam logic [7:0]  SEV_FATAL        = 8'h80;

   // ****************************************************************
   // system status flag positions
   // ****************************************************************
   localparam int FLAG_BATTERY_LOW   = 4;
   localparam int FLAG_CYCLE_OVERRUN = 5;
   localparam int FLAG_NET_MISM_L1   = 6;
   localparam int FLAG_NET_MISM_L0   = 7;
   localparam int FLAG_NET_LINK_L1   = 8;
   localparam int FLAG_NET_LINK_L0   = 9;
   localparam int FLAG_HOST_LINK_L1  = 13;
   localparam int FLAG_HOST_LINK_L0  = 14;
   localparam int FLAG_CPU_DEVICE    = 15;

   // ****************************************************************
   // reset values and timing
   // ****************************************************************
   localparam logic [15:0] WORD_RESET       = 16'h0000;
   localparam logic [15:0] BCD_MAX          = 16'h9999;
   localparam int          CLK_PERIOD_NS    = 10;
   localparam int          TENTH_MS_NS      = 100000;
   localparam int          TENTH_MS_CYCLES  = TENTH_MS_NS / CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_PTR  = 2'b01,
      ST_DATA = 2'b11
   } access_state_t;

   // four-digit bcd increment, wraps 9999 to 0000
   function automatic logic [15:0] bcd_inc(input logic [15:0] v);
      logic [15:0] r;
      logic        c;
      r = v;
      c = 1'b1;
      for (int i = 0; i < 4; i++) begin
         if (c) begin
            if (r[i*4 +: 4] == 4'h9) begin
               r[i*4 +: 4] = 4'h0;
            end else begin
               r[i*4 +: 4] = r[i*4 +: 4] + 4'h1;
               c = 1'b0;
            end
         end
      end
      return r;
   endfunction

   function automatic logic bcd_valid(input logic [15:0] v);
      return (v[15:12] <= 4'h9) && (v[11:8] <= 4'h9) && (v[7:4] <= 4'h9) && (v[3:0] <= 4'h9);
   endfunction

   function automatic logic [13:0] bcd_to_bin(input logic [15:0] v);
      return 14'(v[15:12]) * 14'd1000 + 14'(v[11:8]) * 14'd100
           + 14'(v[7:4]) * 14'd10 + 14'(v[3:0]);
   endfunction

endpackage

// *** design/data_mem_if.sv ***
// carrier between the access controller and the data word memory
`timescale 1ns/1ns
interface data_mem_if;
   logic        we;
   logic [10:0] waddr;
   logic [15:0] wdata;
   logic        re;
   logic [10:0] raddr;
   logic [15:0] rdata;

   modport ctrl (output we, output waddr, output wdata, output re, output raddr,
                 input rdata);
   modport mem  (input we, input waddr, input wdata, input re, input raddr,
                 output rdata);
endinterface

// *** design/data_word_mem.sv ***
// data word memory, whole-word access, registered read data
`timescale 1ns/1ns
module data_word_mem #(
   parameter int DEPTH = 2000
) (
   input  wire logic  mclk,
   input  wire logic  rst_b,
   data_mem_if.mem    port
);
   // no reset on the array: contents ride through power interruptions
   logic [15:0] word_mem [0:DEPTH-1];
   logic [15:0] rdata_reg;

   assign port.rdata = rdata_reg;

   always_ff @(posedge mclk) begin
      if (port.we) begin
         word_mem[port.waddr] <= port.wdata;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         rdata_reg <= status_pkg::WORD_RESET;
      end else if (port.re) begin
         rdata_reg <= word_mem[port.raddr];
      end
   end
endmodule

// *** design/status_words_and_error_history.sv ***
// status words, cycle timing, data word access and error history log
`timescale 1ns/1ns
module status_words_and_error_history #(
   parameter int TENTH_MS_CYCLES = status_pkg::TENTH_MS_CYCLES
) (
   input  wire logic        mclk,
   input  wire logic        rst_b,
   input  wire logic        power_on_pulse,
   input  wire logic        exec_start,
   input  wire logic        scan_end,
   input  wire logic        run_mode,
   input  wire logic [15:0] target_period_bcd,
   input  wire logic        battery_low_pin,
   input  wire logic [1:0]  net_param_mismatch_pin,
   input  wire logic [1:0]  net_link_mounted_pin,
   input  wire logic [1:0]  host_link_mounted_pin,
   input  wire logic        cpu_device_pin,
   input  wire logic        severe_alarm_code,
   input  wire logic [15:0] severe_alarm_addr_bcd,
   input  wire logic        err_valid,
   input  wire logic [7:0]  err_code,
   input  wire logic        err_fatal,
   input  wire logic [7:0]  clk_seconds,
   input  wire logic [7:0]  clk_minutes,
   input  wire logic [7:0]  clk_hours,
   input  wire logic [7:0]  clk_day,
   input  wire logic        log_enable,
   input  wire logic        log_overwrite,
   input  wire logic        log_reset,
   input  wire logic        prog_req,
   input  wire logic        prog_we,
   input  wire logic        prog_indirect,
   input  wire logic        prog_bit_op,
   input  wire logic [10:0] prog_addr,
   input  wire logic [15:0] prog_wdata,
   input  wire logic        periph_we,
   input  wire logic [10:0] periph_addr,
   input  wire logic [15:0] periph_wdata,
   input  wire logic        periph_count_we,
   input  wire logic [15:0] periph_count_wdata,
   output logic             prog_ack,
   output logic             prog_err,
   output logic [15:0]      prog_rdata,
   output logic [15:0]      power_off_count,
   output logic [15:0]      system_status_flags,
   output logic [15:0]      fault_program_address,
   output logic [15:0]      max_cycle_time,
   output logic [15:0]      present_cycle_time,
   output logic [15:0]      error_record_pointer
);

   // ****************************************************************
   // pin synchronisers
   // ****************************************************************
   logic [7:0] pin_meta_reg;
   logic [7:0] pin_sync_reg;
   wire  [7:0] pin_raw = {cpu_device_pin, host_link_mounted_pin, net_link_mounted_pin,
                          net_param_mismatch_pin, battery_low_pin};

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         pin_meta_reg <= 8'h00;
         pin_sync_reg <= 8'h00;
      end else begin
         pin_meta_reg <= pin_raw;
         pin_sync_reg <= pin_meta_reg;
      end
   end

   // ****************************************************************
   // power-off counter
   // ****************************************************************
   logic [15:0] power_count_reg;
   logic [15:0] power_count_next;

   // a power-on in the same clock as a peripheral write still counts
   always_comb begin
      power_count_next = power_count_reg;
      if (periph_count_we) begin
         power_count_next = periph_count_wdata;
      end
      if (power_on_pulse) begin
         power_count_next = status_pkg::bcd_inc(power_count_reg);
      end
   end

   // ****************************************************************
   // cycle time measurement
   // ****************************************************************
   logic [31:0] tick_div_reg;
   logic [15:0] cycle_run_reg;
   logic [15:0] present_reg;
   logic [15:0] max_reg;
   wire         tick      = (tick_div_reg == 32'(TENTH_MS_CYCLES - 1));
   wire         run_sat   = (cycle_run_reg == status_pkg::BCD_MAX);
   wire  [15:0] run_inc   = run_sat ? cycle_run_reg : status_pkg::bcd_inc(cycle_run_reg);
   // bcd digits compare correctly as plain unsigned numbers
   wire         new_max   = (cycle_run_reg > max_reg);

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         tick_div_reg  <= 32'd0;
         cycle_run_reg <= status_pkg::WORD_RESET;
         present_reg   <= status_pkg::WORD_RESET;
         max_reg       <= status_pkg::WORD_RESET;
      end else begin
         tick_div_reg <= (tick || scan_end || exec_start) ? 32'd0 : tick_div_reg + 32'd1;
         if (scan_end || exec_start) begin
            cycle_run_reg <= status_pkg::WORD_RESET;
         end else if (tick) begin
            cycle_run_reg <= run_inc;
         end
         if (scan_end) begin
            present_reg <= cycle_run_reg;
         end
         if (exec_start) begin
            max_reg <= status_pkg::WORD_RESET;
         end else if (scan_end && new_max) begin
            max_reg <= cycle_run_reg;
         end
      end
   end

   // ****************************************************************
   // status flags and fault address
   // ****************************************************************
   logic [15:0] flags_reg;
   logic [15:0] fault_addr_reg;
   logic [15:0] flags_next;

   always_comb begin
      flags_next = flags_reg;
      if (scan_end) begin
         if (run_mode) begin
            flags_next[status_pkg::FLAG_BATTERY_LOW]   = pin_sync_reg[0];
            flags_next[status_pkg::FLAG_CYCLE_OVERRUN] =
               (target_period_bcd < cycle_run_reg);
         end
         flags_next[status_pkg::FLAG_NET_MISM_L1]  = pin_sync_reg[2];
         flags_next[status_pkg::FLAG_NET_MISM_L0]  = pin_sync_reg[1];
         flags_next[status_pkg::FLAG_NET_LINK_L1]  = pin_sync_reg[4];
         flags_next[status_pkg::FLAG_NET_LINK_L0]  = pin_sync_reg[3];
         flags_next[status_pkg::FLAG_HOST_LINK_L1] = pin_sync_reg[6];
         flags_next[status_pkg::FLAG_HOST_LINK_L0] = pin_sync_reg[5];
         flags_next[status_pkg::FLAG_CPU_DEVICE]   = pin_sync_reg[7];
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         power_count_reg <= status_pkg::WORD_RESET;
         flags_reg       <= status_pkg::WORD_RESET;
         fault_addr_reg  <= status_pkg::WORD_RESET;
      end else begin
         power_count_reg <= power_count_next;
         flags_reg       <= flags_next;
         if (severe_alarm_code) begin
            fault_addr_reg <= severe_alarm_addr_bcd;
         end
      end
   end

   // ****************************************************************
   // program access controller
   // ****************************************************************
   data_mem_if mem_bus ();

   data_word_mem #(
      .DEPTH (2000)
   ) u_mem (
      .mclk  (mclk),
      .rst_b (rst_b),
      .port  (mem_bus.mem)
   );

   status_pkg::access_state_t state_reg;
   status_pkg::access_state_t state_next;
   logic        ind_we_reg;
   logic [15:0] ind_wdata_reg;
   logic        rd_log_reg;
   logic [4:0]  rd_idx_reg;
   logic [15:0] log_word_reg [0:29];
   logic [15:0] ptr_reg;
   logic        ack_next;
   logic        err_next;
   logic        fsm_we;
   logic [10:0] fsm_waddr;
   logic        fsm_re;
   logic [10:0] fsm_raddr;
   logic [15:0] fsm_wdata;

   // peripheral writes own the write path; a program request waits while periph_we is high
   wire         prog_take  = (state_reg == status_pkg::ST_IDLE) && prog_req && !periph_we;
   wire         addr_ok    = (prog_addr < status_pkg::DATA_WORDS);
   wire         word_fault = prog_bit_op || !addr_ok;
   wire  [15:0] rd_log_word = (rd_idx_reg == 5'd0) ? ptr_reg : log_word_reg[rd_idx_reg - 5'd1];
   wire  [15:0] read_word  = rd_log_reg ? rd_log_word : mem_bus.rdata;
   wire         ptr_ok     = status_pkg::bcd_valid(read_word)
                          && (status_pkg::bcd_to_bin(read_word) < 14'(status_pkg::DATA_WORDS));
   wire  [13:0] ptr_bin    = status_pkg::bcd_to_bin(read_word);
   wire  [10:0] ptr_addr   = ptr_bin[10:0];
   wire         ptr_w_ok   = ptr_addr < status_pkg::PROG_WRITE_LIMIT;

   always_comb begin
      state_next = state_reg;
      ack_next   = 1'b0;
      err_next   = 1'b0;
      fsm_we     = 1'b0;
      fsm_waddr  = prog_addr;
      fsm_wdata  = prog_wdata;
      fsm_re     = 1'b0;
      fsm_raddr  = prog_addr;
      unique case (state_reg)
         status_pkg::ST_IDLE: begin
            if (prog_take) begin
               if (word_fault) begin
                  ack_next = 1'b1;
                  err_next = 1'b1;
               end else if (prog_indirect) begin
                  fsm_re     = 1'b1;
                  state_next = status_pkg::ST_PTR;
               end else if (prog_we) begin
                  ack_next = 1'b1;
                  if (prog_addr < status_pkg::PROG_WRITE_LIMIT) begin
                     fsm_we = 1'b1;
                  end else begin
                     err_next = 1'b1;
                  end
               end else begin
                  fsm_re     = 1'b1;
                  state_next = status_pkg::ST_DATA;
               end
            end
         end
         status_pkg::ST_PTR: begin
            fsm_raddr = ptr_addr;
            fsm_waddr = ptr_addr;
            fsm_wdata = ind_wdata_reg;
            if (!ptr_ok) begin
               ack_next   = 1'b1;
               err_next   = 1'b1;
               state_next = status_pkg::ST_IDLE;
            end else if (ind_we_reg) begin
               ack_next   = 1'b1;
               state_next = status_pkg::ST_IDLE;
               // a peripheral write this clock would collide; refuse the program write
               if (ptr_w_ok && !periph_we) begin
                  fsm_we = 1'b1;
               end else begin
                  err_next = 1'b1;
               end
            end else begin
               fsm_re     = 1'b1;
               state_next = status_pkg::ST_DATA;
            end
         end
         status_pkg::ST_DATA: begin
            ack_next   = 1'b1;
            state_next = status_pkg::ST_IDLE;
         end
         default: begin
            state_next = status_pkg::ST_IDLE;
         end
      endcase
   end

   // ****************************************************************
   // write routing: log range goes to the log registers
   // ****************************************************************
   wire  [10:0] wr_addr  = periph_we ? periph_addr : fsm_waddr;
   wire  [15:0] wr_data  = periph_we ? periph_wdata : fsm_wdata;
   wire         wr_en    = (periph_we && (periph_addr < status_pkg::DATA_WORDS)) || fsm_we;
   wire         wr_log   = (wr_addr >= status_pkg::LOG_PTR_ADDR)
                        && (wr_addr <= status_pkg::LOG_LAST_ADDR);
   wire  [4:0]  wr_idx   = 5'(wr_addr - status_pkg::LOG_PTR_ADDR);
   wire         rd_log   = (fsm_raddr >= status_pkg::LOG_PTR_ADDR)
                        && (fsm_raddr <= status_pkg::LOG_LAST_ADDR);

   assign mem_bus.we    = wr_en && !wr_log;
   assign mem_bus.waddr = wr_addr;
   assign mem_bus.wdata = wr_data;
   assign mem_bus.re    = fsm_re && !rd_log;
   assign mem_bus.raddr = fsm_raddr;

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         state_reg     <= status_pkg::ST_IDLE;
         ind_we_reg    <= 1'b0;
         ind_wdata_reg <= status_pkg::WORD_RESET;
         rd_log_reg    <= 1'b0;
         rd_idx_reg    <= 5'd0;
      end else begin
         state_reg <= state_next;
         if (prog_take) begin
            ind_we_reg    <= prog_we;
            ind_wdata_reg <= prog_wdata;
         end
         if (fsm_re) begin
            rd_log_reg <= rd_log;
            rd_idx_reg <= 5'(fsm_raddr - status_pkg::LOG_PTR_ADDR);
         end
      end
   end

   // ****************************************************************
   // error history log
   // ****************************************************************
   logic        log_reset_dly_reg;
   logic [15:0] log_word_next [0:29];
   logic [15:0] ptr_next;
   logic [15:0] base_ptr;
   logic [4:0]  rec_base;
   // reset acts on the falling edge of the reset bit, only while enabled
   wire         log_clear = log_reset_dly_reg && !log_reset && log_enable;
   wire         log_event = err_valid && log_enable;
   wire  [15:0] rec_code  = {err_fatal ? status_pkg::SEV_FATAL : status_pkg::SEV_NON_FATAL,
                             err_code};
   wire  [15:0] rec_time  = {clk_minutes, clk_seconds};
   wire  [15:0] rec_date  = {clk_day, clk_hours};

   always_comb begin
      log_word_next = log_word_reg;
      ptr_next      = ptr_reg;
      if (wr_en && wr_log) begin
         if (wr_idx == 5'd0) begin
            ptr_next = wr_data;
         end else begin
            log_word_next[wr_idx - 5'd1] = wr_data;
         end
      end
      if (log_clear) begin
         for (int i = 0; i < status_pkg::LOG_WORDS; i++) begin
            log_word_next[i] = status_pkg::WORD_RESET;
         end
         ptr_next = status_pkg::LOG_PTR_EMPTY;
      end
      // an error in the clearing clock lands in record 1
      base_ptr = log_clear ? status_pkg::LOG_PTR_EMPTY : ptr_reg;
      rec_base = 5'(base_ptr[3:0]) * 5'd3;
      if (log_event) begin
         if (base_ptr < status_pkg::LOG_PTR_FULL) begin
            log_word_next[rec_base]        = rec_code;
            log_word_next[rec_base + 5'd1] = rec_time;
            log_word_next[rec_base + 5'd2] = rec_date;
            ptr_next = base_ptr + 16'h0001;
         end else if (log_overwrite) begin
            for (int i = 0; i < status_pkg::LOG_WORDS - status_pkg::LOG_REC_WORDS; i++) begin
               log_word_next[i] = log_word_reg[i + status_pkg::LOG_REC_WORDS];
            end
            log_word_next[status_pkg::LOG_LAST_REC_IDX]        = rec_code;
            log_word_next[status_pkg::LOG_LAST_REC_IDX + 5'd1] = rec_time;
            log_word_next[status_pkg::LOG_LAST_REC_IDX + 5'd2] = rec_date;
            ptr_next = status_pkg::LOG_PTR_FULL;
         end
         // full and no overwrite: records and pointer stay as they are
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         log_reset_dly_reg <= 1'b0;
         ptr_reg           <= status_pkg::LOG_PTR_EMPTY;
         for (int i = 0; i < status_pkg::LOG_WORDS; i++) begin
            log_word_reg[i] <= status_pkg::WORD_RESET;
         end
      end else begin
         log_reset_dly_reg <= log_reset;
         ptr_reg           <= ptr_next;
         log_word_reg      <= log_word_next;
      end
   end

   // ****************************************************************
   // registered outputs
   // ****************************************************************
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         prog_ack              <= 1'b0;
         prog_err              <= 1'b0;
         prog_rdata            <= status_pkg::WORD_RESET;
         power_off_count       <= status_pkg::WORD_RESET;
         system_status_flags   <= status_pkg::WORD_RESET;
         fault_program_address <= status_pkg::WORD_RESET;
         max_cycle_time        <= status_pkg::WORD_RESET;
         present_cycle_time    <= status_pkg::WORD_RESET;
         error_record_pointer  <= status_pkg::LOG_PTR_EMPTY;
      end else begin
         prog_ack <= ack_next;
         prog_err <= err_next;
         if (state_reg == status_pkg::ST_DATA) begin
            prog_rdata <= read_word;
         end
         power_off_count       <= power_count_next;
         system_status_flags   <= flags_next;
         fault_program_address <= severe_alarm_code ? severe_alarm_addr_bcd : fault_addr_reg;
         max_cycle_time        <= max_reg;
         present_cycle_time    <= present_reg;
         error_record_pointer  <= ptr_next;
      end
   end

endmodule

// *** bench/status_chk.sv ***
// assertions on the status block ports
`timescale 1ns/1ns
module status_chk (
   input wire logic        mclk, rst_b, power_on_pulse, periph_count_we,
   input wire logic        severe_alarm_code, scan_end, err_valid, log_enable, log_reset,
   input wire logic [15:0] periph_count_wdata, severe_alarm_addr_bcd, power_off_count,
   input wire logic [15:0] system_status_flags, fault_program_address, error_record_pointer
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   count_step_a: assert property (power_on_pulse && power_off_count[3:0] != 4'h9
      |=> power_off_count == $past(power_off_count) + 16'h0001) else $error("count step");
   count_load_a: assert property (periph_count_we && !power_on_pulse
      |=> power_off_count == $past(periph_count_wdata)) else $error("count load");
   fault_take_a: assert property (severe_alarm_code
      |=> fault_program_address == $past(severe_alarm_addr_bcd)) else $error("fault take");
   fault_hold_a: assert property (!severe_alarm_code |=> $stable(fault_program_address))
      else $error("fault hold");
   flags_hold_a: assert property (!scan_end |=> $stable(system_status_flags))
      else $error("flags hold");
   ptr_range_a: assert property (error_record_pointer <= 16'h000A)
      else $error("ptr range");
   ptr_step_a: assert property (err_valid && log_enable && !log_reset && !$past(log_reset)
      && error_record_pointer < 16'h000A |=> error_record_pointer ==
      $past(error_record_pointer) + 16'h0001) else $error("ptr step");
   ptr_full_a: assert property (err_valid && log_enable && !log_reset && !$past(log_reset)
      && error_record_pointer == 16'h000A |=> error_record_pointer == 16'h000A)
      else $error("ptr full");
endmodule

// *** bench/periph_device.sv ***
// peripheral programming device model
`timescale 1ns/1ns
module periph_device (
   input  wire logic   mclk,
   output logic        periph_we = 0,
   output logic        periph_count_we = 0,
   output logic [10:0] periph_addr = 0,
   output logic [15:0] periph_wdata = 0,
   output logic [15:0] periph_count_wdata = 0
);
   // released data shows the inverse so a stale value never looks valid
   task automatic ww(input logic [10:0] a, input logic [15:0] d);
      {periph_we, periph_addr, periph_wdata} = {1'b1, a, d};
      @(posedge mclk);
      #1 {periph_we, periph_wdata} = {1'b0, ~d};
      @(posedge mclk);
      #1;
   endtask
   task automatic wc(input logic [15:0] d);
      {periph_count_we, periph_count_wdata} = {1'b1, d};
      @(posedge mclk);
      #1 {periph_count_we, periph_count_wdata} = {1'b0, ~d};
   endtask
endmodule

// *** bench/tb_top.sv ***
// bench for the status block
`timescale 1ns/1ns
module tb_top;
   logic mclk=0, rst_b=0, power_on_pulse=0, exec_start=0, scan_end=0, run_mode=0;
   logic battery_low_pin=0, cpu_device_pin=0, severe_alarm_code=0, err_valid=0, err_fatal=0;
   logic log_enable=0, log_overwrite=0, log_reset=0, prog_req=0, prog_we=0, prog_indirect=0;
   logic prog_bit_op=0, periph_we, periph_count_we, prog_ack, prog_err;
   logic [1:0] net_param_mismatch_pin=0, net_link_mounted_pin=0, host_link_mounted_pin=0;
   logic [7:0] err_code=0, clk_seconds=8'h59, clk_minutes=8'h23, clk_hours=8'h11, clk_day=8'h15;
   logic [10:0] prog_addr=0, periph_addr;
   logic [15:0] target_period_bcd=0, severe_alarm_addr_bcd=0, prog_wdata=0, periph_wdata;
   logic [15:0] periph_count_wdata, prog_rdata, power_off_count, system_status_flags;
   logic [15:0] fault_program_address, max_cycle_time, present_cycle_time, error_record_pointer;
   int n_errors=0, check_count=0;
   always #5 mclk = ~mclk;
   status_words_and_error_history #(.TENTH_MS_CYCLES(4)) status_words_and_error_history_inst (.*);
   periph_device periph_device_inst (.*);
   task automatic tk;
      @(posedge mclk);
      #1;
   endtask
   task automatic chk(input string n, input logic [15:0] s, e);
      check_count++;
      if (s !== e) begin
         n_errors++;
         $display("wrong value %s exp %h got %h", n, e, s);
      end
   endtask
   // 0EEE stands for a refused request; a missing ack never matches
   task automatic pr(input logic [10:0] a, input logic [2:0] m, input logic [15:0] d, e);
      {prog_addr, prog_we, prog_indirect, prog_bit_op, prog_wdata, prog_req} = {a, m, d, 1'b1};
      tk;
      repeat (3) if (prog_ack !== 1'b1) tk;
      prog_req = 0;
      chk("prog", prog_ack ? (prog_err ? 16'h0EEE : m[2] ? e : prog_rdata) : 16'hDEAD, e);
      tk;
   endtask
   task automatic er(input logic [7:0] c);
      {err_valid, err_code, err_fatal} = {1'b1, c, c[0]};
      tk;
      err_valid = 0;
      tk;
   endtask
   task automatic sc;
      repeat (3) tk;
      scan_end = 1;
      tk;
      scan_end = 0;
   endtask
   task automatic summarize;
      if (n_errors == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      repeat (2) tk;
      rst_b = 1;
      chk("count", power_off_count, 16'h0000);
      periph_device_inst.wc(16'h0998);
      for (int k = 0; k < 2; k++) begin
         power_on_pulse = 1;
         tk;
         power_on_pulse = 0;
         chk("count", power_off_count, k ? 16'h1000 : 16'h0999);
         tk;
      end
      {severe_alarm_code, severe_alarm_addr_bcd} = {1'b1, 16'h0417};
      tk;
      severe_alarm_code = 0;
      chk("fault", fault_program_address, 16'h0417);
      {battery_low_pin, net_param_mismatch_pin, net_link_mounted_pin, host_link_mounted_pin,
       cpu_device_pin, run_mode, target_period_bcd} = {9'h1FF, 16'h0001};
      exec_start = 1;
      tk;
      exec_start = 0;
      repeat (9) tk;
      sc;
      chk("flags", system_status_flags, 16'hE3F0);
      {battery_low_pin, run_mode} = 2'b00;
      sc;
      chk("flags", system_status_flags, 16'hE3F0);
      chk("max", max_cycle_time, 16'h0003);
      chk("present", present_cycle_time, 16'h0003);
      periph_device_inst.ww(11'h5DC, 16'hBEEF);
      periph_device_inst.ww(11'h064, 16'h0324);
      pr(11'h5DC, 3'b000, 16'h0000, 16'hBEEF);
      pr(11'h5DC, 3'b100, 16'h0000, 16'h0EEE);
      pr(11'h064, 3'b110, 16'h5A5A, 16'h5A5A);
      pr(11'h144, 3'b000, 16'h0000, 16'h5A5A);
      pr(11'h064, 3'b001, 16'h0000, 16'h0EEE);
      er(8'h41);
      chk("ptr", error_record_pointer, 16'h0000);
      log_enable = 1;
      for (int i = 1; i <= 10; i++) begin
         er(8'h40 + 8'(i));
         chk("ptr", error_record_pointer, 16'(i));
      end
      for (int s = 0; s < 2; s++) begin
         log_overwrite = 1'(s);
         er(8'h56);
         chk("ptr", error_record_pointer, 16'h000A);
         pr(11'h3CA, 3'b000, 16'h0000, s ? 16'h0042 : 16'h8041);
         pr(11'h3E5, 3'b000, 16'h0000, s ? 16'h0056 : 16'h004A);
      end
      pr(11'h3CB, 3'b000, 16'h0000, 16'h2359);
      log_reset = 1;
      tk;
      log_reset = 0;
      tk;
      chk("ptr", error_record_pointer, 16'h0000);
      pr(11'h3E5, 3'b000, 16'h0000, 16'h0000);
      summarize;
   end
   initial begin
      #100000;
      n_errors++;
      summarize;
   end
endmodule
bind status_words_and_error_history status_chk status_chk_inst (.*);
